// [core/lvd_pkg.sv]
/*
 * Shared constants for the low-voltage detector control block: register
 * offsets, bit positions, reset values and timing counts.
 * Assumes a 250 MHz system clock; all users refer to names with the package scope.
 */
package lvd_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFF_CONTROL   = 4'h0;
    localparam logic [3:0] OFF_IRQ_FLAG  = 4'h1;
    localparam logic [3:0] OFF_IRQ_MASK  = 4'h2;
    localparam logic [3:0] OFF_RST_STAT  = 4'h3;

    // Control register field positions.
    localparam int unsigned BIT_COMPARE = 0;
    localparam int unsigned BIT_ACTION  = 1;
    localparam int unsigned BIT_SOURCE  = 2;
    localparam int unsigned BIT_ENABLE  = 7;

    // Interrupt request flag position in the low flag register 0.
    localparam int unsigned BIT_IRQ_REQ = 1;

    // Mask register reset value: detector interrupt masked.
    localparam logic [7:0] MASK_RESET    = 8'h02;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Detection delay, longest allowed, in microseconds; rounded down to cycles.
    localparam int unsigned DETECT_DELAY_US = 200;
    localparam int unsigned DETECT_DELAY_CYC = DETECT_DELAY_US * CLK_MHZ;
    localparam int unsigned CNT_W = 16;

endpackage

// [core/lvd_sync_if.sv]
/*
 * Interface carrying the filtered comparator state from the debounce
 * filter to the control logic. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface lvd_sync_if;
    logic below;     // Filtered: watched voltage below threshold.
    logic changed;   // One-cycle pulse when the filtered level changes.

    modport filt (output below, output changed);
    modport ctrl (input below, input changed);
endinterface

// [core/lvd_filter.sv]
/*
 * Detection delay filter: the raw comparator level must hold steady for
 * a programmed number of cycles before the filtered level follows.
 * Assumes the raw input is already synchronised to clk_sys_i.
 */
`timescale 1ns/1ps
module lvd_filter #(
    parameter int unsigned DELAY_CYC = lvd_pkg::DETECT_DELAY_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic enable_i,
    input  wire logic raw_below_i,
    lvd_sync_if.filt  sync
);

    localparam logic [lvd_pkg::CNT_W-1:0] LIMIT = lvd_pkg::CNT_W'(DELAY_CYC - 1);

    logic [lvd_pkg::CNT_W-1:0] cnt_q;

    // Count while the raw level differs from the filtered one; a glitch restarts it.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else if (!enable_i || raw_below_i == sync.below) begin
            cnt_q <= '0;
        end else if (cnt_q != LIMIT) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Filtered level follows once the count expires, DELAY_CYC cycles after the raw level last began to differ.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync.below   <= 1'b0;
            sync.changed <= 1'b0;
        end else begin
            sync.changed <= 1'b0;
            if (enable_i && raw_below_i != sync.below && cnt_q == LIMIT) begin
                sync.below   <= raw_below_i;
                sync.changed <= 1'b1;
            end
        end
    end

endmodule

// [core/low_voltage_detect_control.sv]
/*
 * Control logic of the low-voltage detector: control register, request
 * flag, mask, reset request and interrupt output.
 * Assumes the analog comparators are outside and deliver raw levels
 * asynchronous to clk_sys_i; the CPU uses the plain register port.
 */
// Summary of operation
// - Every reset sets the detector interrupt mask, masking the interrupt.
// - Source select bit 2: one watches external input, zero watches supply.
// - Action select bit 1 at zero, its default, makes detection interrupt.
// - Enable bit 7 written to one turns detection on.
// - Bit 0 shows whether watched voltage is below the threshold.
// - A threshold crossing in interrupt mode raises request and sets flags.
// - Disabling while below threshold raises the interrupt request.
// - A threshold level change may set the request flag.
// - Request flag is bit 1 of flag register 0 low, cleared writing zero.
// - Detection reaches reset within 200 us on falling and recovering; the code takes DELAY_CYC plus 2 to 3 cycles, over 200 us at the default.
// - Action select set to one makes detection raise an internal reset.
`timescale 1ns/1ps
module low_voltage_detect_control #(
    parameter int unsigned DELAY_CYC = lvd_pkg::DETECT_DELAY_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       supply_below_i,
    input  wire logic       external_below_i,
    input  wire logic       level_changed_i,
    output logic            detect_irq_o,
    output logic            detect_reset_o,
    output logic            detect_on_o,
    output logic            source_ext_o
);

    lvd_sync_if sync ();

    logic       enable_q;
    logic       source_q;
    logic       action_q;
    logic       req_flag_q;
    logic       mask_q;
    logic       rst_seen_q;
    logic [1:0] sup_meta_q;
    logic [1:0] ext_meta_q;
    logic       lvl_meta_q;
    logic       lvl_sync_q;
    logic       lvl_prev_q;
    logic       raw_below;
    logic       wr_ctl;
    logic       wr_flag;
    logic       wr_mask;
    logic       wr_rst;
    logic       disable_evt;
    logic       detect_evt;
    logic       level_evt;
    logic       set_req;

    // Two-stage synchronisers; the first stage is read only by the second stage.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sup_meta_q <= 2'h0;
            ext_meta_q <= 2'h0;
            lvl_meta_q <= 1'b0;
            lvl_sync_q <= 1'b0;
            lvl_prev_q <= 1'b0;
        end else begin
            sup_meta_q <= {sup_meta_q[0], supply_below_i};
            ext_meta_q <= {ext_meta_q[0], external_below_i};
            lvl_meta_q <= level_changed_i;
            lvl_sync_q <= lvl_meta_q;
            lvl_prev_q <= lvl_sync_q;
        end
    end

    // Pick the watched comparator.
    assign raw_below = source_q ? ext_meta_q[1] : sup_meta_q[1];

    lvd_filter #(
        .DELAY_CYC (DELAY_CYC)
    ) u_filter (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .enable_i    (enable_q),
        .raw_below_i (raw_below),
        .sync        (sync.filt)
    );

    // Register write decodes.
    assign wr_ctl  = reg_wr_i && reg_addr_i == lvd_pkg::OFF_CONTROL;
    assign wr_flag = reg_wr_i && reg_addr_i == lvd_pkg::OFF_IRQ_FLAG;
    assign wr_mask = reg_wr_i && reg_addr_i == lvd_pkg::OFF_IRQ_MASK;
    assign wr_rst  = reg_wr_i && reg_addr_i == lvd_pkg::OFF_RST_STAT;

    // Turning detection off while the filtered level is below raises a request.
    assign disable_evt = wr_ctl && enable_q && !reg_wdata_i[lvd_pkg::BIT_ENABLE] && sync.below;
    // Any filtered crossing in interrupt mode raises a request.
    assign detect_evt  = enable_q && !action_q && sync.changed;
    // A threshold level change pulse from the level select logic.
    assign level_evt   = enable_q && lvl_sync_q && !lvl_prev_q;
    assign set_req     = disable_evt || detect_evt || level_evt;

    // Control bits; the compare bit is not stored and ignores writes.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_q <= lvd_pkg::CONTROL_RESET[lvd_pkg::BIT_ENABLE];
            source_q <= lvd_pkg::CONTROL_RESET[lvd_pkg::BIT_SOURCE];
            action_q <= lvd_pkg::CONTROL_RESET[lvd_pkg::BIT_ACTION];
        end else if (wr_ctl) begin
            enable_q <= reg_wdata_i[lvd_pkg::BIT_ENABLE];
            source_q <= reg_wdata_i[lvd_pkg::BIT_SOURCE];
            action_q <= reg_wdata_i[lvd_pkg::BIT_ACTION];
        end
    end

    // Sticky request flag; a new event wins over a software clear in the same cycle.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_flag_q <= 1'b0;
        end else if (set_req) begin
            req_flag_q <= 1'b1;
        end else if (wr_flag && !reg_wdata_i[lvd_pkg::BIT_IRQ_REQ]) begin
            req_flag_q <= 1'b0;
        end
    end

    // Mask comes up set after every reset so nothing fires before software is ready.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask_q <= lvd_pkg::MASK_RESET[lvd_pkg::BIT_IRQ_REQ];
        end else if (wr_mask) begin
            mask_q <= reg_wdata_i[lvd_pkg::BIT_IRQ_REQ];
        end
    end

    // The internal reset request follows the filtered level in reset mode.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            detect_reset_o <= 1'b0;
        end else begin
            detect_reset_o <= enable_q && action_q && sync.below;
        end
    end

    // Sticky record that a detector reset was requested, cleared by writing one.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_seen_q <= 1'b0;
        end else if (detect_reset_o) begin
            rst_seen_q <= 1'b1;
        end else if (wr_rst && reg_wdata_i[0]) begin
            rst_seen_q <= 1'b0;
        end
    end

    // Level interrupt while the request is pending and unmasked.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            detect_irq_o <= 1'b0;
        end else begin
            detect_irq_o <= (req_flag_q || set_req) && !mask_q;
        end
    end

    // Status mirrors for the analog side.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            detect_on_o  <= 1'b0;
            source_ext_o <= 1'b0;
        end else begin
            detect_on_o  <= enable_q;
            source_ext_o <= source_q;
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= 8'h00;
            case (reg_addr_i)
                lvd_pkg::OFF_CONTROL: begin
                    reg_rdata_o[lvd_pkg::BIT_ENABLE]  <= enable_q;
                    reg_rdata_o[lvd_pkg::BIT_SOURCE]  <= source_q;
                    reg_rdata_o[lvd_pkg::BIT_ACTION]  <= action_q;
                    reg_rdata_o[lvd_pkg::BIT_COMPARE] <= sync.below;
                end
                lvd_pkg::OFF_IRQ_FLAG: begin
                    reg_rdata_o[lvd_pkg::BIT_IRQ_REQ] <= req_flag_q;
                end
                lvd_pkg::OFF_IRQ_MASK: begin
                    reg_rdata_o[lvd_pkg::BIT_IRQ_REQ] <= mask_q;
                end
                lvd_pkg::OFF_RST_STAT: begin
                    reg_rdata_o[0] <= rst_seen_q;
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// [tb/low_voltage_detect_control_checker.sv]
/*
 * Concurrent checks on the ports of the low-voltage detector control block.
 * Assumes one clock domain and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
module low_voltage_detect_control_checker #(
    parameter int unsigned DELAY_CYC = lvd_pkg::DETECT_DELAY_CYC
) (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       detect_irq_o,
    input wire logic       detect_reset_o,
    input wire logic       detect_on_o,
    input wire logic       source_ext_o
);
    // All checks share the system clock, so one default suffices.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_reserved_bits: assert property (reg_rd_i && reg_addr_i == lvd_pkg::OFF_CONTROL |=> reg_rdata_o[6:3] == 4'h0)
        else $error("reserved control bits read nonzero");
    a_unmapped_read: assert property (reg_rd_i && reg_addr_i > 4'h3 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Two cycles allow for an extra output register behind the stored bit.
    a_enable_follows: assert property (reg_wr_i && reg_addr_i == lvd_pkg::OFF_CONTROL ##1 !reg_wr_i
        |=> detect_on_o == $past(reg_wdata_i[7], 2)) else $error("enable output does not follow write");
    a_source_follows: assert property (reg_wr_i && reg_addr_i == lvd_pkg::OFF_CONTROL ##1 !reg_wr_i
        |=> source_ext_o == $past(reg_wdata_i[2], 2)) else $error("source output does not follow write");
    a_irq_after_reset: assert property ($fell(sys_rst_i) |-> !detect_irq_o ##1 !detect_irq_o)
        else $error("interrupt high right after reset");
    a_irq_masked: assert property (reg_wr_i && reg_addr_i == lvd_pkg::OFF_IRQ_MASK && reg_wdata_i[1]
        |-> ##2 !detect_irq_o) else $error("interrupt high while masked");
    a_irq_sticky: assert property (detect_irq_o && !$past(reg_wr_i) |=> detect_irq_o)
        else $error("interrupt dropped without a write");
    a_reset_needs_en: assert property (detect_reset_o |-> detect_on_o || $past(detect_on_o))
        else $error("detector reset while detection off");
endmodule

bind low_voltage_detect_control low_voltage_detect_control_checker #(.DELAY_CYC(DELAY_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .detect_irq_o(detect_irq_o),
    .detect_reset_o(detect_reset_o), .detect_on_o(detect_on_o), .source_ext_o(source_ext_o));

// [tb/tb.sv]
/*
 * Self-checking bench for the low-voltage detector control block.
 * Assumes the comparator inputs are driven here; a short filter delay is used.
 */
`timescale 1ns/1ps
module tb;
    localparam int unsigned DLY = 8;
    logic       clk_sys_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic       supply_below_i = 1'b0;
    logic       external_below_i = 1'b0;
    logic       level_changed_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       detect_irq_o;
    logic       detect_reset_o;
    logic       detect_on_o;
    logic       source_ext_o;
    int         fails = 0;
    int         checked = 0;
    int         seed = 75008;
    int         m_ctrl = 0;
    int         m_mask = 1;
    int         m_flag = 0;
    int         m_below = 0;
    logic [7:0] d;

    low_voltage_detect_control #(.DELAY_CYC(DLY)) u_low_voltage_detect_control (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .supply_below_i(supply_below_i),
        .external_below_i(external_below_i), .level_changed_i(level_changed_i), .detect_irq_o(detect_irq_o),
        .detect_reset_o(detect_reset_o), .detect_on_o(detect_on_o), .source_ext_o(source_ext_o));

    // Free-running system clock.
    always #2 clk_sys_i = ~clk_sys_i;

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write; the model follows the documented side effects.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        if (a == lvd_pkg::OFF_CONTROL) begin
            if (m_ctrl[7] && !v[7] && m_below != 0) m_flag = 1;
            m_ctrl = int'(v & 8'h86);
        end
        if (a == lvd_pkg::OFF_IRQ_FLAG && !v[1]) m_flag = 0;
        if (a == lvd_pkg::OFF_IRQ_MASK) m_mask = int'(v[1]);
    endtask

    // Register read compared against the model; data stand one cycle later.
    task automatic rd(input logic [3:0] a);
        logic [7:0] e;
        case (a)
            lvd_pkg::OFF_CONTROL: e = 8'(m_ctrl | m_below);
            lvd_pkg::OFF_IRQ_FLAG: e = 8'(m_flag << 1);
            lvd_pkg::OFF_IRQ_MASK: e = 8'(m_mask << 1);
            default: e = 8'h00;
        endcase
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 cmp_reg(reg_rdata_o, e);
    endtask

    // The interrupt is registered behind flag and mask, so allow two edges.
    task automatic chk_irq;
        repeat (2) @(posedge clk_sys_i);
        #1 cmp_pin(detect_irq_o, m_flag != 0 && m_mask == 0);
    endtask

    // Synchroniser, filter and output register must all have been passed.
    task automatic settle;
        repeat (DLY + 6) @(posedge clk_sys_i);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the couple of hundred cycles the tests need.
    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(lvd_pkg::OFF_CONTROL);
        rd(lvd_pkg::OFF_IRQ_MASK);
        rd(lvd_pkg::OFF_IRQ_FLAG);
        $display("test reset_values done");
        // Random control words; the compare bit must ignore writes.
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            wr(lvd_pkg::OFF_CONTROL, d);
            rd(lvd_pkg::OFF_CONTROL);
            cmp_pin(detect_on_o, d[7]);
            cmp_pin(source_ext_o, d[2]);
        end
        for (int a = 4; a < 16; a++) rd(4'(a));
        wr(lvd_pkg::OFF_CONTROL, 8'h00);
        $display("test control_rw done");
        // Interrupt start-up on the external input, in the documented order.
        wr(lvd_pkg::OFF_IRQ_MASK, 8'h02);
        wr(lvd_pkg::OFF_CONTROL, 8'h84);
        external_below_i <= 1'b1;
        settle();
        m_below = 1;
        m_flag = 1;
        rd(lvd_pkg::OFF_CONTROL);
        rd(lvd_pkg::OFF_IRQ_FLAG);
        chk_irq();
        wr(lvd_pkg::OFF_IRQ_FLAG, 8'h02);
        chk_irq();
        wr(lvd_pkg::OFF_IRQ_MASK, 8'h00);
        chk_irq();
        wr(lvd_pkg::OFF_IRQ_FLAG, 8'h00);
        chk_irq();
        wr(lvd_pkg::OFF_CONTROL, 8'h00);
        chk_irq();
        wr(lvd_pkg::OFF_IRQ_FLAG, 8'h00);
        external_below_i <= 1'b0;
        $display("test irq_external done");
        // Switching to the supply, which is above threshold, is a crossing.
        wr(lvd_pkg::OFF_CONTROL, 8'h80);
        settle();
        m_below = 0;
        m_flag = 1;
        rd(lvd_pkg::OFF_IRQ_FLAG);
        rd(lvd_pkg::OFF_CONTROL);
        wr(lvd_pkg::OFF_IRQ_FLAG, 8'h00);
        level_changed_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        m_flag = 1;
        rd(lvd_pkg::OFF_IRQ_FLAG);
        chk_irq();
        level_changed_i <= 1'b0;
        wr(lvd_pkg::OFF_IRQ_FLAG, 8'h00);
        $display("test supply_level done");
        // Reset action: a drop asserts the internal reset, recovery releases it.
        wr(lvd_pkg::OFF_CONTROL, 8'h82);
        supply_below_i <= 1'b1;
        settle();
        m_below = 1;
        cmp_pin(detect_reset_o, 1'b1);
        rd(lvd_pkg::OFF_IRQ_FLAG);
        supply_below_i <= 1'b0;
        settle();
        m_below = 0;
        cmp_pin(detect_reset_o, 1'b0);
        wr(lvd_pkg::OFF_CONTROL, 8'h00);
        $display("test reset_mode done");
        // A second reset in mid-run must mask the interrupt again.
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        m_mask = 1;
        m_flag = 0;
        m_ctrl = 0;
        // Software lets a short fluctuation period pass before touching the block.
        repeat (4) @(posedge clk_sys_i);
        rd(lvd_pkg::OFF_IRQ_MASK);
        cmp_pin(detect_irq_o, 1'b0);
        $display("test second_reset done");
        summarize();
    end
endmodule
